// ==== rtl/boot_strap_defines.vh ====
/*
 * Constants of the boot strap latch: register offsets, field positions,
 * reset values and decoded code points.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef BOOT_STRAP_DEFINES_VH
`define BOOT_STRAP_DEFINES_VH

// ==========================================================================
// Register offsets (byte addresses, one aligned 32-bit word each)
// ==========================================================================
`define BSL_OFS_STATUS      12'h000
`define BSL_OFS_OVERRIDE    12'h004
`define BSL_OFS_STATE       12'h008

// ==========================================================================
// Strap status fields
// ==========================================================================
`define BSL_STS_LDO         0
`define BSL_STS_BOOT_A      1
`define BSL_STS_BOOT_B      2
`define BSL_STS_LOG_TIMING  3
`define BSL_STS_SDIO_TIMING 4
`define BSL_NUM_STRAPS      5

// ==========================================================================
// Override fields
// ==========================================================================
`define BSL_OVR_LDO_EN      0
`define BSL_OVR_LDO_1V8     1
`define BSL_OVR_SDIO_EN     2
`define BSL_OVR_SAMPLE_RISE 3
`define BSL_OVR_OUTPUT_RISE 4
`define BSL_OVR_WIDTH       5
`define BSL_OVR_RESET       5'h00

// ==========================================================================
// State fields
// ==========================================================================
`define BSL_ST_IN_RESET     0
`define BSL_ST_VALID        1

// ==========================================================================
// Pull directions per strap, bit order as the status fields
// ==========================================================================
`define BSL_PULL_UP_MASK    5'h1A
`define BSL_PULL_DOWN_MASK  5'h05
`define BSL_STRAP_RESET     5'h00

// ==========================================================================
// Boot mode codes
// ==========================================================================
`define BSL_BOOT_DOWNLOAD   2'h0
`define BSL_BOOT_SPI        2'h1
`define BSL_BOOT_INVALID    2'h2

`endif

// ==== rtl/strap_sync.v ====
/*
 * Two-stage synchroniser for a group of level signals.
 * Assumes a single clock; the stages have no reset so that they follow
 * the pads while the power-on reset is held.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
    parameter WIDTH = 5
) (
    input  wire             clk,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // ======================================================================
    // Synchroniser stages
    // ======================================================================
    // The first stage is read by the second stage only. No reset here: a
    // reset would hide the pad levels from the capture that follows the
    // release of the power-on reset.
    always @(posedge clk) begin
        meta_q   <= async_in;
        sync_out <= meta_q;
    end

endmodule // strap_sync

`default_nettype wire

// ==== rtl/boot_strap_latch.v ====
/*
 * Boot strap latch: samples five strap pins when system reset is released,
 * holds them until the next system reset release, decodes boot settings and exposes the caught straps on APB.
 * Assumes RST_N is the power-on reset, MOD_EN and the reset request inputs
 * form the system reset, and pad pulls are resolved outside this module.
 */
`timescale 1ns/1ps
`default_nettype none
`include "boot_strap_defines.vh"

module boot_strap_latch (
    input  wire        CLK_SYS,
    input  wire        RST_N,
    input  wire        MOD_EN,
    input  wire        WDT_RST_REQ,
    input  wire        BROWNOUT_RST_REQ,
    input  wire        LDO_VOLTAGE_STRAP,
    input  wire        BOOT_SELECT_A,
    input  wire        BOOT_SELECT_B,
    input  wire        LOG_AND_TIMING_STRAP,
    input  wire        SDIO_TIMING_STRAP,
    output reg  [4:0]  STRAP_PULL_UP_EN,
    output reg  [4:0]  STRAP_PULL_DOWN_EN,
    output reg         STRAP_FUNC_EN,
    output reg         SYS_IN_RESET,
    output reg         LDO_SEL_1V8,
    output reg  [1:0]  BOOT_MODE,
    output reg         UART0_TRANSMIT_LOG_EN,
    output reg         SDIO_SAMPLE_RISE,
    output reg         SDIO_OUTPUT_RISE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR
);

    // ======================================================================
    // Declarations
    // ======================================================================
    wire [4:0]  pin_raw;
    wire [4:0]  pin_sync;
    wire        sys_rst;
    wire        capture;
    wire        access;
    wire        hit_status;
    wire        hit_override;
    wire        hit_state;
    wire        hit_any;

    reg         in_rst_q;
    reg         valid_q;
    reg  [4:0]  strap_q;
    reg  [4:0]  ovr_q;
    reg  [4:0]  ovr_d;
    reg  [31:0] rdata_d;

    reg         ldo_d;
    reg  [1:0]  boot_d;
    reg         sample_d;
    reg         output_d;

    // ======================================================================
    // System reset
    // ======================================================================
    // Module enable low, a watchdog request or a brownout all hold the
    // system in reset; only RST_N, the power-on reset, clears the latch.
    assign sys_rst = ~MOD_EN | WDT_RST_REQ | BROWNOUT_RST_REQ;

    // Release is the first cycle with the system reset gone after a cycle
    // with it present.
    assign capture = in_rst_q & ~sys_rst;

    // Tracks the system reset level one cycle late to find its release.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            in_rst_q <= 1'b1;
        end else begin
            in_rst_q <= sys_rst;
        end
    end

    // ======================================================================
    // Strap pin synchronisation
    // ======================================================================
    assign pin_raw[`BSL_STS_LDO]         = LDO_VOLTAGE_STRAP;
    assign pin_raw[`BSL_STS_BOOT_A]      = BOOT_SELECT_A;
    assign pin_raw[`BSL_STS_BOOT_B]      = BOOT_SELECT_B;
    assign pin_raw[`BSL_STS_LOG_TIMING]  = LOG_AND_TIMING_STRAP;
    assign pin_raw[`BSL_STS_SDIO_TIMING] = SDIO_TIMING_STRAP;

    // The pads are asynchronous to the system clock, so each level passes
    // two flip-flops before it may be caught.
    strap_sync #(
        .WIDTH    (`BSL_NUM_STRAPS)
    ) u_sync (
        .clk      (CLK_SYS),
        .async_in (pin_raw),
        .sync_out (pin_sync)
    );

    // ======================================================================
    // Pad control
    // ======================================================================
    // Weak pulls are held only while the system is in reset so that an
    // open pin reads its default level; afterwards the pad belongs to its
    // normal function and the pulls are released.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            STRAP_PULL_UP_EN   <= `BSL_PULL_UP_MASK;
            STRAP_PULL_DOWN_EN <= `BSL_PULL_DOWN_MASK;
            STRAP_FUNC_EN      <= 1'b0;
            SYS_IN_RESET       <= 1'b1;
        end else begin
            STRAP_PULL_UP_EN   <= sys_rst ? `BSL_PULL_UP_MASK : 5'h00;
            STRAP_PULL_DOWN_EN <= sys_rst ? `BSL_PULL_DOWN_MASK : 5'h00;
            STRAP_FUNC_EN      <= ~sys_rst & ~in_rst_q;
            SYS_IN_RESET       <= sys_rst;
        end
    end

    // ======================================================================
    // Strap latch
    // ======================================================================
    // Loaded only on a release edge; pin activity at any other time has no
    // effect. The trade-off is that a strap changed during a long reset is
    // seen only as it stands two cycles before the release.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            strap_q <= `BSL_STRAP_RESET;
            valid_q <= 1'b0;
        end else if (capture) begin
            strap_q <= pin_sync;
            valid_q <= 1'b1;
        end
    end

    // ======================================================================
    // Decode of the caught straps with firmware override
    // ======================================================================
    always @* begin
        // LDO voltage: override bit wins when its enable is set.
        if (ovr_q[`BSL_OVR_LDO_EN]) begin
            ldo_d = ovr_q[`BSL_OVR_LDO_1V8];
        end else begin
            ldo_d = strap_q[`BSL_STS_LDO];
        end

        // Boot A high is SPI regardless of boot B; both low is download.
        if (strap_q[`BSL_STS_BOOT_A]) begin
            boot_d = `BSL_BOOT_SPI;
        end else if (!strap_q[`BSL_STS_BOOT_B]) begin
            boot_d = `BSL_BOOT_DOWNLOAD;
        end else begin
            boot_d = `BSL_BOOT_INVALID;
        end

        // SDIO edges: log strap picks sampling, SDIO strap picks output.
        if (ovr_q[`BSL_OVR_SDIO_EN]) begin
            sample_d = ovr_q[`BSL_OVR_SAMPLE_RISE];
            output_d = ovr_q[`BSL_OVR_OUTPUT_RISE];
        end else begin
            sample_d = strap_q[`BSL_STS_LOG_TIMING];
            output_d = strap_q[`BSL_STS_SDIO_TIMING];
        end
    end

    // Decoded settings leave through flip-flops.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            LDO_SEL_1V8           <= 1'b0;
            BOOT_MODE             <= `BSL_BOOT_DOWNLOAD;
            UART0_TRANSMIT_LOG_EN <= 1'b0;
            SDIO_SAMPLE_RISE      <= 1'b0;
            SDIO_OUTPUT_RISE      <= 1'b0;
        end else begin
            LDO_SEL_1V8           <= ldo_d;
            BOOT_MODE             <= boot_d;
            UART0_TRANSMIT_LOG_EN <= strap_q[`BSL_STS_LOG_TIMING];
            SDIO_SAMPLE_RISE      <= sample_d;
            SDIO_OUTPUT_RISE      <= output_d;
        end
    end

    // ======================================================================
    // APB slave
    // ======================================================================
    // One wait state: the access phase is answered on its second edge,
    // which lets read data and the error flag come straight from flops.
    assign access       = PSEL & PENABLE & ~PREADY;
    assign hit_status   = (PADDR == `BSL_OFS_STATUS);
    assign hit_override = (PADDR == `BSL_OFS_OVERRIDE);
    assign hit_state    = (PADDR == `BSL_OFS_STATE);
    assign hit_any      = hit_status | hit_override | hit_state;

    // Read multiplexer; unused upper bits read as zero.
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_status) begin
            rdata_d[4:0] = strap_q;
        end else if (hit_override) begin
            rdata_d[4:0] = ovr_q;
        end else if (hit_state) begin
            rdata_d[`BSL_ST_IN_RESET] = in_rst_q;
            rdata_d[`BSL_ST_VALID]    = valid_q;
        end
    end

    // Override write; a system reset returns control to the straps.
    always @* begin
        ovr_d = ovr_q;
        if (sys_rst) begin
            ovr_d = `BSL_OVR_RESET;
        end else if (access && PWRITE && hit_override) begin
            ovr_d = PWDATA[`BSL_OVR_WIDTH-1:0];
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ovr_q <= `BSL_OVR_RESET;
        end else begin
            ovr_q <= ovr_d;
        end
    end

    // Handshake and answer registers. The status and state words are read
    // only, so a write to them is refused with an error like a miss.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= access;
            PSLVERR <= access & (~hit_any | (PWRITE & ~hit_override));
            if (access && !PWRITE) begin
                PRDATA <= rdata_d;
            end
        end
    end

endmodule // boot_strap_latch

`default_nettype wire

// ==== bench/strap_checker_assertions.sv ====
/* Concurrent checks on the boot strap latch ports.
   Assumes it is bound onto boot_strap_latch, one clock, RST_N low = power-on. */
`timescale 1ns/1ps
`default_nettype none
module strap_checker (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        MOD_EN,
    input wire logic        WDT_RST_REQ,
    input wire logic        BROWNOUT_RST_REQ,
    input wire logic        LDO_VOLTAGE_STRAP,
    input wire logic        BOOT_SELECT_A,
    input wire logic        BOOT_SELECT_B,
    input wire logic        LOG_AND_TIMING_STRAP,
    input wire logic        SDIO_TIMING_STRAP,
    input wire logic [4:0]  STRAP_PULL_UP_EN,
    input wire logic [4:0]  STRAP_PULL_DOWN_EN,
    input wire logic        STRAP_FUNC_EN,
    input wire logic        SYS_IN_RESET,
    input wire logic        LDO_SEL_1V8,
    input wire logic [1:0]  BOOT_MODE,
    input wire logic        UART0_TRANSMIT_LOG_EN,
    input wire logic        SDIO_SAMPLE_RISE,
    input wire logic        SDIO_OUTPUT_RISE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    // ======================================================================
    // Properties
    // Decode checks look four cycles back because the pins pass a synchroniser.
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    wire sys_rst = !MOD_EN || WDT_RST_REQ || BROWNOUT_RST_REQ;
    reset_seen_a: assert property (sys_rst |=> SYS_IN_RESET) else $error("reset not seen");
    pull_level_a: assert property (STRAP_PULL_UP_EN == (SYS_IN_RESET ? 5'h1A : 5'h00)
        && STRAP_PULL_DOWN_EN == (SYS_IN_RESET ? 5'h05 : 5'h00)) else $error("bad pulls");
    func_on_a: assert property ($fell(SYS_IN_RESET) |=> STRAP_FUNC_EN) else $error("pads idle");
    func_off_a: assert property (SYS_IN_RESET |=> !STRAP_FUNC_EN) else $error("pads in use");
    strap_hold_a: assert property (!SYS_IN_RESET && !$past(SYS_IN_RESET)
        && !$past(SYS_IN_RESET, 2) |-> $stable(BOOT_MODE) && $stable(UART0_TRANSMIT_LOG_EN))
        else $error("straps moved");
    boot_decode_a: assert property ($fell(SYS_IN_RESET) |=> BOOT_MODE ==
        ($past(BOOT_SELECT_A, 4) ? 2'h1 : ($past(BOOT_SELECT_B, 4) ? 2'h2 : 2'h0)))
        else $error("bad boot mode");
    log_decode_a: assert property ($fell(SYS_IN_RESET) |=>
        UART0_TRANSMIT_LOG_EN == $past(LOG_AND_TIMING_STRAP, 4)) else $error("bad log");
    ldo_decode_a: assert property ($fell(SYS_IN_RESET) |=>
        LDO_SEL_1V8 == $past(LDO_VOLTAGE_STRAP, 4)) else $error("bad ldo");
    sdio_decode_a: assert property ($fell(SYS_IN_RESET) |=>
        {SDIO_SAMPLE_RISE, SDIO_OUTPUT_RISE} == {$past(LOG_AND_TIMING_STRAP, 4),
        $past(SDIO_TIMING_STRAP, 4)}) else $error("bad sdio edges");
    apb_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("no answer");
    apb_refuse_a: assert property (PREADY && PSEL && PADDR != 12'h004 && (PWRITE ||
        (PADDR != 12'h000 && PADDR != 12'h008)) |-> PSLVERR) else $error("not refused");
endmodule // strap_checker
bind boot_strap_latch strap_checker chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .MOD_EN(MOD_EN),
    .WDT_RST_REQ(WDT_RST_REQ), .BROWNOUT_RST_REQ(BROWNOUT_RST_REQ),
    .LDO_VOLTAGE_STRAP(LDO_VOLTAGE_STRAP), .BOOT_SELECT_A(BOOT_SELECT_A),
    .BOOT_SELECT_B(BOOT_SELECT_B), .LOG_AND_TIMING_STRAP(LOG_AND_TIMING_STRAP),
    .SDIO_TIMING_STRAP(SDIO_TIMING_STRAP), .STRAP_PULL_UP_EN(STRAP_PULL_UP_EN),
    .STRAP_PULL_DOWN_EN(STRAP_PULL_DOWN_EN), .STRAP_FUNC_EN(STRAP_FUNC_EN),
    .SYS_IN_RESET(SYS_IN_RESET), .LDO_SEL_1V8(LDO_SEL_1V8), .BOOT_MODE(BOOT_MODE),
    .UART0_TRANSMIT_LOG_EN(UART0_TRANSMIT_LOG_EN), .SDIO_SAMPLE_RISE(SDIO_SAMPLE_RISE),
    .SDIO_OUTPUT_RISE(SDIO_OUTPUT_RISE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

// ==== bench/strap_host.sv ====
/* Far side of the strap pins: host drivers or board pulls per pin.
   Assumes the pull enables come from the latch. */
`timescale 1ns/1ps
`default_nettype none
module strap_host (
    input  wire logic       clk,
    input  wire logic [4:0] pull_up,
    input  wire logic [4:0] pull_down,
    input  wire logic [4:0] drive_en,
    input  wire logic [4:0] drive_val,
    output var  logic [4:0] pins = 5'h00
);
    // ======================================================================
    // Pin levels
    // A pin with neither driver nor pull toggles, so no stale level looks valid.
    always @(posedge clk) begin
        pins <= (drive_en & drive_val) | (~drive_en & pull_up)
            | (~drive_en & ~pull_up & ~pull_down & ~pins);
    end
endmodule // strap_host
`default_nettype wire

// ==== bench/boot_strap_latch_tb.sv ====
/* Self-checking bench of the boot strap latch: APB tasks and reset sequences.
   Assumes the strap_host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module boot_strap_latch_tb;
    // ======================================================================
    // Stimulus and observed signals
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        mod_en = 1'b1;
    logic        wdt = 1'b0;
    logic        bod = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [4:0]  drv_en = 5'h00;
    logic [4:0]  drv_val = 5'h00;
    logic [4:0]  pins, pu, pd;
    logic        func_en, in_rst, ldo, log_en, s_rise, o_rise, pready, pslverr, rerr;
    logic [1:0]  boot;
    logic [31:0] prdata, rd;
    int          errors = 0;
    int          compares = 0;
    always #4 clk = ~clk;
    strap_host host (.clk(clk), .pull_up(pu), .pull_down(pd), .drive_en(drv_en),
        .drive_val(drv_val), .pins(pins));
    boot_strap_latch uut (.CLK_SYS(clk), .RST_N(rst_n), .MOD_EN(mod_en), .WDT_RST_REQ(wdt),
        .BROWNOUT_RST_REQ(bod), .LDO_VOLTAGE_STRAP(pins[0]), .BOOT_SELECT_A(pins[1]),
        .BOOT_SELECT_B(pins[2]), .LOG_AND_TIMING_STRAP(pins[3]), .SDIO_TIMING_STRAP(pins[4]),
        .STRAP_PULL_UP_EN(pu), .STRAP_PULL_DOWN_EN(pd), .STRAP_FUNC_EN(func_en),
        .SYS_IN_RESET(in_rst), .LDO_SEL_1V8(ldo), .BOOT_MODE(boot),
        .UART0_TRANSMIT_LOG_EN(log_en), .SDIO_SAMPLE_RISE(s_rise), .SDIO_OUTPUT_RISE(o_rise),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until PREADY is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected decode of a captured strap word, seen at the pins and in status.
    task automatic expect_straps(input logic [4:0] s);
        check(ldo, s[0]);
        check(boot, s[1] ? 2'h1 : (s[2] ? 2'h2 : 2'h0));
        check(log_en, s[3]);
        check({s_rise, o_rise}, {s[3], s[4]});
        check({func_en, pu, pd}, 11'h400);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, {27'h0, s});
    endtask
    // Source 0 lowers the module enable, 1 is the watchdog, 2 the brownout.
    task automatic restart(input int src, input logic [4:0] en, input logic [4:0] v);
        @(posedge clk);
        drv_en <= en;
        drv_val <= v;
        mod_en <= (src != 0);
        wdt <= (src == 1);
        bod <= (src == 2);
        repeat (6) @(posedge clk);
        check({in_rst, pu, pd}, 11'h745);
        mod_en <= 1'b1;
        wdt <= 1'b0;
        bod <= 1'b0;
        repeat (6) @(posedge clk);
        expect_straps((en & v) | (~en & 5'h1A));
    endtask
    task automatic summarize;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ======================================================================
    // Tests
    initial begin
        logic [4:0] ens [6] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h03};
        logic [4:0] vals [6] = '{5'h00, 5'h1F, 5'h04, 5'h08, 5'h10, 5'h01};
        repeat (16) @(posedge clk);
        check({in_rst, pu, pd}, 11'h745);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        expect_straps(5'h1A);
        $display("test power_on done");
        for (int i = 0; i < 6; i++) restart(i % 3, ens[i], vals[i]);
        $display("test strap_table done");
        drv_val <= ~drv_val;
        repeat (4) @(posedge clk);
        expect_straps(5'h19);
        $display("test hold done");
        apb(1'b1, 12'h004, 32'h07);
        @(negedge clk);
        check({rerr, ldo, s_rise, o_rise}, 4'h4);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h07);
        $display("test override done");
        apb(1'b1, 12'h000, 32'h1F);
        check(rerr, 1'b1);
        apb(1'b1, 12'h008, 32'h0);
        check(rerr, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        check(rerr, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        check({rerr, rd}, 33'h2);
        $display("test refusals done");
        restart(2, 5'h1F, 5'h0E);
        $display("test override cleared done");
        summarize();
    end
    // Hang guard, far beyond the roughly 180 cycles the tests need.
    initial begin
        #100000;
        errors++;
        summarize();
    end
endmodule // boot_strap_latch_tb
`default_nettype wire
